// >>> iex_consts.svh
// offsets, field positions, reset values and cycle counts of the interrupt dispatch block
`ifndef IEX_CONSTS_SVH
`define IEX_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define IEX_OFF_MASK 4'h0
`define IEX_OFF_FLAGS 4'h4
`define IEX_OFF_GCTRL 4'h8
`define IEX_OFF_GIE 4'hc

// ************************************************************
// field positions
// ************************************************************
`define IEX_BIT_B 7
`define IEX_BIT_A 6
`define IEX_BIT_GIE 0

// ************************************************************
// vectors and cycle counts
// ************************************************************
`define IEX_VEC_A 13'h0002
`define IEX_VEC_B 13'h0004
`define IEX_ENTRY_CYC 4'h4
`define IEX_WAKE_EXTRA 4'h4
`define IEX_RET_CYC 4'h4

// ************************************************************
// sense codes, responses, reset values
// ************************************************************
`define IEX_SENSE_LEVEL 2'h0
`define IEX_SENSE_ANY 2'h1
`define IEX_SENSE_FALL 2'h2
`define IEX_SENSE_RISE 2'h3
`define IEX_RESP_OKAY 2'h0
`define IEX_RESP_SLVERR 2'h2
`define IEX_RST_SENSE 4'h0

`endif

// >>> iex_core_model.sv
// behavioural processor core that drives and watches the dispatch block
`timescale 1ns/1ps
module iex_core_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // from the dispatch block
   input wire logic entry_active,
   input wire logic ret_active,
   input wire logic vec_load,
   input wire logic [12:0] vec_addr,
   input wire logic push_strobe,
   input wire logic [7:0] push_byte,
   input wire logic pop_strobe,
   input wire logic ret_done,
   // bench control
   input wire logic sleep_cmd,
   // core side
   output logic insn_done,
   output logic core_asleep,
   output logic [12:0] core_pc,
   // observations
   output logic [12:0] last_vec,
   output logic [15:0] push_word,
   output logic [12:0] acc_pc,
   output logic [7:0] ent_cnt,
   output logic [7:0] ret_cnt,
   output logic [7:0] pop_cnt,
   output logic [3:0] ent_len,
   output logic [3:0] ret_len,
   output logic [7:0] late
);
   logic [1:0] ph;
   logic [3:0] ec, rc;
   logic ea_d, ra_d, bnd_d, pst, pst_d, woke;
   logic [12:0] pc_d;

   // a wake request drops sleep once entry has begun
   assign core_asleep = sleep_cmd & ~woke;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {insn_done, core_pc, last_vec, push_word, acc_pc, ent_cnt, ret_cnt} <= '0;
         {pop_cnt, ent_len, ret_len, late, ph, ec, rc} <= '0;
         {ea_d, ra_d, bnd_d, pst, pst_d, woke, pc_d} <= '0;
      end else begin
         // three-cycle instructions; insn_done marks only the last cycle
         if (entry_active | ret_active | core_asleep) begin
            ph <= 2'h0;
            insn_done <= 1'h0;
         end else begin
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            insn_done <= (ph == 2'h1);
         end
         if (insn_done) core_pc <= core_pc + 13'h1;
         if (vec_load) begin
            core_pc <= vec_addr;
            last_vec <= vec_addr;
            ent_cnt <= ent_cnt + 8'h1;
         end
         if (push_strobe) push_word <= {push_byte, push_word[15:8]};
         if (pop_strobe) pop_cnt <= pop_cnt + 8'h1;
         if (ret_done) ret_cnt <= ret_cnt + 8'h1;
         // status word is never exchanged: handler software keeps it
         if (ret_done) pst <= 1'h1;
         else if (insn_done) pst <= 1'h0;
         bnd_d <= insn_done | core_asleep;
         pc_d <= core_pc;
         pst_d <= pst;
         ea_d <= entry_active;
         ra_d <= ret_active;
         // entry seen one edge late, so the delayed copies hold the accept cycle
         if (entry_active && !ea_d) begin
            acc_pc <= pc_d;
            if (pst_d || !bnd_d) late <= late + 8'h1;
         end
         if (entry_active) ec <= ec + 4'h1;
         else if (ea_d) begin
            ent_len <= ec;
            ec <= 4'h0;
         end
         if (ret_active) rc <= rc + 4'h1;
         else if (ra_d) begin
            ret_len <= rc;
            rc <= 4'h0;
         end
         if (!sleep_cmd) woke <= 1'h0;
         else if (entry_active) woke <= 1'h1;
      end
   end
endmodule

// >>> iex_dispatch.sv
// interrupt dispatch with two external pin sources and an axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "iex_consts.svh"

module iex_dispatch
   import iex_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // processor core
   input wire logic insn_done,
   input wire logic core_asleep,
   input wire logic return_from_handler_instr_start,
   input wire logic [12:0] core_pc,
   output logic global_enable,
   output logic entry_active,
   output logic ret_active,
   output logic vec_load,
   output logic [12:0] vec_addr,
   output logic push_strobe,
   output logic [7:0] push_byte,
   output logic pop_strobe,
   output logic ret_done,
   // external request pins
   input wire logic ext_request_a,
   input wire logic ext_request_b
);

   // ************************************************************
   // helpers
   // ************************************************************
   localparam iex_state_t IEX_RESET = '0;

   iex_state_t s;
   iex_state_t next_s;

   // {hit, offset}: word aligned and inside the four-register window
   function automatic logic [4:0] iex_decode(input logic [ADDR_W-1:0] a);
      logic hit;
      hit = ((a >> 4) == '0) && (a[1:0] == 2'h0);
      return {hit, a[3:0]};
   endfunction

   // trigger on the synchronised pin; level code never sets a flag
   function automatic logic iex_trig(input logic [1:0] sense,
                                     input logic cur,
                                     input logic prev);
      logic t;
      t = 1'b0;
      case (sense)
         `IEX_SENSE_ANY: t = cur ^ prev;
         `IEX_SENSE_FALL: t = prev & ~cur;
         `IEX_SENSE_RISE: t = cur & ~prev;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // ************************************************************
   // request evaluation
   // ************************************************************
   logic level_a;
   logic level_b;
   logic trig_a;
   logic trig_b;
   logic req_a;
   logic req_b;
   logic accept;
   logic [4:0] wr_dec;
   logic [4:0] rd_dec;
   logic wr_now;
   logic wr_hit;
   logic [31:0] rd_val;

   // pin taps come after the second flop; the direction of a change is looked at only for the fall and rise codes
   assign level_a = s.sense[1:0] == `IEX_SENSE_LEVEL;
   assign level_b = s.sense[3:2] == `IEX_SENSE_LEVEL;
   assign trig_a = iex_trig(s.sense[1:0], s.sync_a[1], s.sync_a[2]);
   assign trig_b = iex_trig(s.sense[3:2], s.sync_b[1], s.sync_b[2]);
   // level request follows the pin itself, edge request the flag
   assign req_a = s.en_a & (level_a ? ~s.sync_a[1] : s.flag_a);
   assign req_b = s.en_b & (level_b ? ~s.sync_b[1] : s.flag_b);
   // a sleeping core is not mid-instruction, so it may be taken at once
   assign accept = (s.st == IEX_IDLE) & s.gie & (req_a | req_b)
                   & (insn_done | core_asleep) & ~return_from_handler_instr_start;

   assign wr_now = s.aw_got & s.w_got & ~s.bvalid;
   assign wr_dec = {~s.aw_bad, s.aw_off};
   assign wr_hit = wr_now & wr_dec[4] & s.wlane;
   assign rd_dec = iex_decode(s_axi_araddr);

   always_comb begin
      rd_val = 32'h0000_0000;
      case (rd_dec[3:0])
         `IEX_OFF_MASK: rd_val = {24'h00_0000, s.en_b, s.en_a, 6'h00};
         `IEX_OFF_FLAGS: rd_val = {24'h00_0000, s.flag_b, s.flag_a, 6'h00};
         `IEX_OFF_GCTRL: rd_val = {28'h000_0000, s.sense};
         `IEX_OFF_GIE: rd_val = {31'h0000_0000, s.gie};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_s = s;
      next_s.vec_load = 1'b0;
      next_s.push_strobe = 1'b0;
      next_s.pop_strobe = 1'b0;
      next_s.ret_done = 1'b0;
      // first flop feeds only the second
      next_s.sync_a = {s.sync_a[1:0], ext_request_a};
      next_s.sync_b = {s.sync_b[1:0], ext_request_b};

      // axi write channels, taken in either order
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.aw_off = iex_decode(s_axi_awaddr)[3:0];
         next_s.aw_bad = ~iex_decode(s_axi_awaddr)[4];
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wbyte = s_axi_wdata[7:0];
         next_s.wlane = s_axi_wstrb[0];
      end
      if (wr_now) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = s.aw_bad ? `IEX_RESP_SLVERR : `IEX_RESP_OKAY;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_hit && (s.aw_off == `IEX_OFF_MASK)) begin
         next_s.en_b = s.wbyte[`IEX_BIT_B];
         next_s.en_a = s.wbyte[`IEX_BIT_A];
      end
      if (wr_hit && (s.aw_off == `IEX_OFF_GCTRL)) begin
         next_s.sense = s.wbyte[3:0];
      end
      // software may set the enable inside a handler to nest
      if (wr_hit && (s.aw_off == `IEX_OFF_GIE)) begin
         next_s.gie = s.wbyte[`IEX_BIT_GIE];
      end

      // axi read
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_val;
         next_s.rresp = rd_dec[4] ? `IEX_RESP_OKAY : `IEX_RESP_SLVERR;
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      // sequencer; status word is left to the handler, nothing stacks it
      case (s.st)
         IEX_IDLE: begin
            if (return_from_handler_instr_start) begin
               next_s.st = IEX_RET;
               next_s.cnt = 4'h0;
               next_s.ret_active = 1'b1;
            end else if (accept) begin
               next_s.st = IEX_ENTRY;
               next_s.cnt = 4'h0;
               next_s.src_b = ~req_a;
               next_s.pc_hold = core_pc;
               next_s.len = core_asleep ? 4'(`IEX_ENTRY_CYC + `IEX_WAKE_EXTRA)
                                        : `IEX_ENTRY_CYC;
               next_s.entry_active = 1'b1;
               next_s.gie = 1'b0;
            end
         end
         IEX_ENTRY: begin
            next_s.cnt = 4'(s.cnt + 4'h1);
            // pc goes out low byte first
            if (s.cnt == 4'h0) begin
               next_s.push_strobe = 1'b1;
               next_s.push_byte = s.pc_hold[7:0];
            end
            if (s.cnt == 4'h1) begin
               next_s.push_strobe = 1'b1;
               next_s.push_byte = {3'h0, s.pc_hold[12:8]};
            end
            if (s.cnt == 4'(s.len - 4'h1)) begin
               next_s.st = IEX_IDLE;
               next_s.entry_active = 1'b0;
               next_s.vec_load = 1'b1;
               next_s.vec_addr = s.src_b ? `IEX_VEC_B : `IEX_VEC_A;
            end
         end
         IEX_RET: begin
            next_s.cnt = 4'(s.cnt + 4'h1);
            // each pop moves the stack pointer by one, two in all
            if (s.cnt < 4'h2) begin
               next_s.pop_strobe = 1'b1;
            end
            if (s.cnt == 4'(`IEX_RET_CYC - 4'h1)) begin
               next_s.st = IEX_POST;
               next_s.ret_active = 1'b0;
               next_s.ret_done = 1'b1;
               next_s.gie = 1'b1;
            end
         end
         IEX_POST: begin
            // hold off dispatch until the core retires one instruction
            if (return_from_handler_instr_start) begin
               next_s.st = IEX_RET;
               next_s.cnt = 4'h0;
               next_s.ret_active = 1'b1;
            end else if (insn_done) begin
               next_s.st = IEX_IDLE;
            end
         end
         default: begin
            next_s.st = IEX_IDLE;
         end
      endcase

      // flags: clears first, a new event overrides them
      if (s.st == IEX_ENTRY && s.cnt == 4'(s.len - 4'h1)) begin
         if (s.src_b) begin
            next_s.flag_b = 1'b0;
         end else begin
            next_s.flag_a = 1'b0;
         end
      end
      if (wr_hit && (s.aw_off == `IEX_OFF_FLAGS)) begin
         if (s.wbyte[`IEX_BIT_B]) begin
            next_s.flag_b = 1'b0;
         end
         if (s.wbyte[`IEX_BIT_A]) begin
            next_s.flag_a = 1'b0;
         end
      end
      if (trig_a) begin
         next_s.flag_a = 1'b1;
      end
      if (trig_b) begin
         next_s.flag_b = 1'b1;
      end
      if (level_a) begin
         next_s.flag_a = 1'b0;
      end
      if (level_b) begin
         next_s.flag_b = 1'b0;
      end

      next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
      next_s.wready = ~next_s.w_got & ~next_s.bvalid;
      next_s.arready = ~next_s.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= IEX_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign global_enable = s.gie;
   assign entry_active = s.entry_active;
   assign ret_active = s.ret_active;
   assign vec_load = s.vec_load;
   assign vec_addr = s.vec_addr;
   assign push_strobe = s.push_strobe;
   assign push_byte = s.push_byte;
   assign pop_strobe = s.pop_strobe;
   assign ret_done = s.ret_done;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_entry_clears_gie: assert property (accept |=> !s.gie[*4])
      else $error("enable not cleared on entry");
   chk_return_sets_gie: assert property (ret_done |-> s.gie && $past(s.ret_active))
      else $error("enable not set on return");
   chk_vector_clears_flag: assert property (
      vec_load && vec_addr == `IEX_VEC_A && !$past(trig_a) |-> !s.flag_a)
      else $error("flag a left set after vector");
   chk_w1c_flag: assert property (
      wr_hit && s.aw_off == `IEX_OFF_FLAGS && s.wbyte[`IEX_BIT_B] && !trig_b
      |=> !s.flag_b)
      else $error("write one did not clear flag b");
   chk_disabled_sets: assert property (trig_a && !level_a && !s.en_a |=> s.flag_a)
      else $error("event lost while disabled");
   chk_level_no_flag: assert property (level_b && $past(level_b) |-> !s.flag_b)
      else $error("flag b set in level mode");
   chk_entry_awake: assert property (
      accept && !core_asleep |=> entry_active[*4] ##1 (vec_load && !entry_active))
      else $error("entry length wrong");
   chk_entry_asleep: assert property (accept && core_asleep |-> ##9 vec_load)
      else $error("wake entry length wrong");
   chk_push_two: assert property (accept |-> ##2 push_strobe ##1 push_strobe ##1 !push_strobe)
      else $error("pc push pattern wrong");
   chk_return_len: assert property (
      s.st == IEX_IDLE && return_from_handler_instr_start |-> ##2 pop_strobe[*2] ##1 !pop_strobe ##1 ret_done)
      else $error("return sequence wrong");
   chk_boundary_only: assert property (accept |-> insn_done || core_asleep)
      else $error("entry taken mid-instruction");
   chk_post_hold: assert property (ret_done |-> !accept throughout (!insn_done)[*2])
      else $error("dispatch right after return");
   chk_priority: assert property (accept && req_a |=> !s.src_b)
      else $error("priority order wrong");
   chk_level_request: assert property (
      level_a && s.en_a && !s.sync_a[1] && s.gie && s.st == IEX_IDLE && insn_done
      && !return_from_handler_instr_start |-> accept)
      else $error("level request not served");

   cov_entry_awake: cover property (accept && !core_asleep ##5 vec_load);
   cov_entry_wake: cover property (accept && core_asleep ##9 vec_load);
   cov_return: cover property (ret_done ##[1:20] accept);
   cov_both_pending: cover property (accept && req_a && req_b);

endmodule

// >>> iex_pkg.sv
// types of the interrupt dispatch block
package iex_pkg;

   typedef enum logic [1:0] {
      IEX_IDLE,
      IEX_ENTRY,
      IEX_RET,
      IEX_POST
   } iex_phase_t;

   typedef struct packed {
      iex_phase_t st;
      logic [3:0] cnt;
      logic [3:0] len;
      logic src_b;
      logic [12:0] pc_hold;
      logic [2:0] sync_a;
      logic [2:0] sync_b;
      logic en_a;
      logic en_b;
      logic flag_a;
      logic flag_b;
      logic [3:0] sense;
      logic gie;
      logic aw_got;
      logic [3:0] aw_off;
      logic aw_bad;
      logic w_got;
      logic [7:0] wbyte;
      logic wlane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic entry_active;
      logic ret_active;
      logic vec_load;
      logic [12:0] vec_addr;
      logic push_strobe;
      logic [7:0] push_byte;
      logic pop_strobe;
      logic ret_done;
   } iex_state_t;

endpackage

// >>> tb_iex_dispatch.sv
// self-checking bench of the interrupt dispatch block
`timescale 1ns/1ps
`include "iex_consts.svh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_iex_dispatch;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, ent_len, ret_len;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, insn_done, core_asleep, return_from_handler_instr_start, global_enable, entry_active;
   logic ret_active, vec_load, push_strobe, pop_strobe, ret_done, sleep_cmd;
   logic ext_request_a, ext_request_b;
   logic [12:0] core_pc, vec_addr, last_vec, acc_pc;
   logic [7:0] push_byte, ent_cnt, ret_cnt, pop_cnt, late;
   logic [15:0] push_word;
   int error_cnt = 0;
   int checks_done = 0;

   iex_dispatch dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .insn_done, .core_asleep, .return_from_handler_instr_start,
      .core_pc, .global_enable, .entry_active, .ret_active, .vec_load, .vec_addr,
      .push_strobe, .push_byte, .pop_strobe, .ret_done, .ext_request_a, .ext_request_b);
   iex_core_model core_u (.aclk, .aresetn, .entry_active, .ret_active, .vec_load, .vec_addr,
      .push_strobe, .push_byte, .pop_strobe, .ret_done, .sleep_cmd, .insn_done, .core_asleep,
      .core_pc, .last_vec, .push_word, .acc_pc, .ent_cnt, .ret_cnt, .pop_cnt, .ent_len,
      .ret_len, .late);

   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // address and data are offered together and each is dropped once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ad, wd;
      ad = 1'h0;
      wd = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'h1) begin
            ad = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!wd && s_axi_wready === 1'h1) begin
            wd = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (s_axi_bvalid !== 1'h1) @(posedge aclk);
      s_axi_bready <= 1'h0;
      `CHK("bresp", er, s_axi_bresp)
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1) @(posedge aclk);
      s_axi_rready <= 1'h0;
      `CHK("rdata", {24'h0, e}, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask

   // pins go through a synchroniser, so let them settle
   task automatic setp(input logic a, input logic b);
      @(posedge aclk);
      ext_request_a <= a;
      ext_request_b <= b;
      repeat (6) @(posedge aclk);
   endtask

   task automatic wt(input logic [7:0] n);
      while (ent_cnt !== n) @(posedge aclk);
   endtask

   task automatic ret(input logic [7:0] n);
      @(posedge aclk);
      return_from_handler_instr_start <= 1'h1;
      @(posedge aclk);
      return_from_handler_instr_start <= 1'h0;
      while (ret_cnt !== n) @(posedge aclk);
   endtask

   initial begin
      #400us;
      error_cnt++;
      conclude();
   end

   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, return_from_handler_instr_start, sleep_cmd} = '0;
      {ext_request_a, ext_request_b} = 2'h3;
      aresetn = 1'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 4; i++) rd(4'(i * 4), 8'h00, `IEX_RESP_OKAY);
      wr(4'h2, 8'hff, `IEX_RESP_SLVERR);
      rd(4'h2, 8'h00, `IEX_RESP_SLVERR);
      wr(`IEX_OFF_MASK, 8'hff, `IEX_RESP_OKAY);
      rd(`IEX_OFF_MASK, 8'hc0, `IEX_RESP_OKAY);
      wr(`IEX_OFF_MASK, 8'h00, `IEX_RESP_OKAY);
      for (int c = 1; c < 4; c++) begin
         wr(`IEX_OFF_GCTRL, 8'(c * 5), `IEX_RESP_OKAY);
         rd(`IEX_OFF_GCTRL, 8'(c * 5), `IEX_RESP_OKAY);
         wr(`IEX_OFF_FLAGS, 8'hff, `IEX_RESP_OKAY);
         setp(1'h0, 1'h0);
         rd(`IEX_OFF_FLAGS, (c != 3) ? 8'hc0 : 8'h00, `IEX_RESP_OKAY);
         wr(`IEX_OFF_FLAGS, 8'hff, `IEX_RESP_OKAY);
         setp(1'h1, 1'h1);
         rd(`IEX_OFF_FLAGS, (c != 2) ? 8'hc0 : 8'h00, `IEX_RESP_OKAY);
      end
      wr(`IEX_OFF_FLAGS, 8'h00, `IEX_RESP_OKAY);
      rd(`IEX_OFF_FLAGS, 8'hc0, `IEX_RESP_OKAY);
      wr(`IEX_OFF_FLAGS, 8'h40, `IEX_RESP_OKAY);
      rd(`IEX_OFF_FLAGS, 8'h80, `IEX_RESP_OKAY);
      wr(`IEX_OFF_GCTRL, 8'h00, `IEX_RESP_OKAY);
      rd(`IEX_OFF_FLAGS, 8'h00, `IEX_RESP_OKAY);
      setp(1'h0, 1'h0);
      rd(`IEX_OFF_FLAGS, 8'h00, `IEX_RESP_OKAY);
      setp(1'h1, 1'h1);
      // both pending while disabled, then released together
      wr(`IEX_OFF_GCTRL, 8'h0f, `IEX_RESP_OKAY);
      setp(1'h0, 1'h0);
      setp(1'h1, 1'h1);
      wr(`IEX_OFF_MASK, 8'hc0, `IEX_RESP_OKAY);
      repeat (10) @(posedge aclk);
      `CHK("entries", 8'h00, ent_cnt)
      rd(`IEX_OFF_FLAGS, 8'hc0, `IEX_RESP_OKAY);
      wr(`IEX_OFF_GIE, 8'h01, `IEX_RESP_OKAY);
      wt(8'h1);
      `CHK("vector", `IEX_VEC_A, last_vec)
      `CHK("entry_len", `IEX_ENTRY_CYC, ent_len)
      `CHK("pushed_pc", {3'h0, acc_pc}, push_word)
      rd(`IEX_OFF_GIE, 8'h00, `IEX_RESP_OKAY);
      rd(`IEX_OFF_FLAGS, 8'h80, `IEX_RESP_OKAY);
      ret(8'h1);
      `CHK("gie", 1'h1, global_enable)
      `CHK("pops", 8'h02, pop_cnt)
      `CHK("ret_len", `IEX_RET_CYC, ret_len)
      wt(8'h2);
      `CHK("vector", `IEX_VEC_B, last_vec)
      rd(`IEX_OFF_FLAGS, 8'h00, `IEX_RESP_OKAY);
      ret(8'h2);
      // wake from sleep by an edge on pin a
      wr(`IEX_OFF_MASK, 8'h40, `IEX_RESP_OKAY);
      sleep_cmd <= 1'h1;
      setp(1'h0, 1'h1);
      setp(1'h1, 1'h1);
      wt(8'h3);
      sleep_cmd <= 1'h0;
      `CHK("entry_len", `IEX_ENTRY_CYC + `IEX_WAKE_EXTRA, ent_len)
      ret(8'h3);
      // level request: served again after return while the pin stays low
      wr(`IEX_OFF_GCTRL, 8'h00, `IEX_RESP_OKAY);
      setp(1'h0, 1'h1);
      wt(8'h4);
      rd(`IEX_OFF_FLAGS, 8'h00, `IEX_RESP_OKAY);
      ret(8'h4);
      wt(8'h5);
      `CHK("vector", `IEX_VEC_A, last_vec)
      setp(1'h1, 1'h1);
      ret(8'h5);
      repeat (20) @(posedge aclk);
      `CHK("entries", 8'h05, ent_cnt)
      `CHK("late_entry", 8'h00, late)
      `CHK("pops", 8'h0a, pop_cnt)
      conclude();
   end
endmodule
